// ===== hw/sci_break_idle_transmit.sv
// serial transmitter with break and idle line generation
// assumes a one-cycle baud tick per bit time from an outside divider,
// inputs synchronous to core_clk
//
// Notes on behaviour
// - set-then-clear of break request sends one break
// - break is 10 or 11 bits, never doubled
// - held break request repeats breaks, finishes current
// - tx_on off then on queues an idle line
// - break after idle follows it, exact length
`timescale 1ns/100ps
`include "sci_break_consts.svh"
module sci_break_idle_transmit
	import sci_break_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic                  clkEn,
	input  wire logic                  tx_on,
	input  wire logic                  break_request,
	input  wire logic                  nine_bit_mode,
	input  wire logic                  baudTick,
	input  wire logic [`TX_DATA_W-1:0] wrData,
	input  wire logic                  wrValid,
	output wire logic                  wrReady,
	output wire logic                  txLine,
	output wire logic                  txBusy,
	output wire logic                  sendingBreak
);
	tx_state_t             state;
	char_kind_t            kind;
	logic [`TX_SHIFT_W-1:0] shifter;
	logic [3:0]            bitsLeft;
	logic                  lineOut;
	logic                  idlePending;
	logic                  breakPending;
	logic                  prevTxOn;
	logic                  prevBreak;

	wire [`TX_DATA_W-1:0]  fifoData;
	wire                   fifoValid;
	wire                   fifoPop;

	// ************************************************
	// data buffer
	// ************************************************
	tx_fifo #(
		.WIDTH (`TX_DATA_W),
		.DEPTH (`TX_FIFO_DEPTH)
	) u_fifo (
		.core_clk (core_clk),
		.rst      (rst),
		.clkEn    (clkEn),
		.inData   (wrData),
		.inValid  (wrValid),
		.inReady  (wrReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (fifoPop)
	);

	// bit times of one character for the word size
	function automatic logic [3:0] charBits(input logic nine);
		charBits = nine ? `CHAR_BITS_9 : `CHAR_BITS_8;
	endfunction : charBits

	// ************************************************
	// launch decisions
	// ************************************************
	// a character starts only on a tick, so every bit is one full baud period
	// edges of the software control bits
	wire       txOnRise   = tx_on & ~prevTxOn;
	wire       breakRise  = break_request & ~prevBreak;

	// an enable edge on a tick already beats any data waiting in the buffer
	wire       slot       = baudTick & ((state == ST_READY) | (bitsLeft == 4'h0));
	wire       idleWant   = idlePending | txOnRise;
	wire       breakWant  = breakPending | break_request;
	wire       startIdle  = slot & tx_on & idleWant;
	wire       startBreak = slot & tx_on & ~idleWant & breakWant;
	wire       startData  = slot & tx_on & ~idleWant & ~breakWant & fifoValid;
	wire       launch     = startIdle | startBreak | startData;
	wire [3:0] charLen    = charBits(nine_bit_mode);

	assign fifoPop = startData & clkEn;

	// ************************************************
	// character patterns
	// ************************************************
	// start bit, data lsb first, stop bit, spare ones above
	wire [`TX_SHIFT_W-1:0] dataPattern  = nine_bit_mode ?
		{2'b11, fifoData, 1'b0} : {3'b111, fifoData[7:0], 1'b0};
	// break of charLen space bits then one mark stop bit
	wire [`TX_SHIFT_W-1:0] breakPattern = nine_bit_mode ?
		`BREAK_PATTERN_9 : `BREAK_PATTERN_8;
	wire [`TX_SHIFT_W-1:0] next_pattern = startIdle ? `IDLE_PATTERN :
		(startBreak ? breakPattern : dataPattern);
	// remaining ticks after the first bit; break carries its stop bit
	wire [3:0]             next_bits    = startBreak ? charLen : 4'(charLen - 4'h1);
	wire char_kind_t       next_kind    = startIdle ? KIND_IDLE :
		(startBreak ? KIND_BREAK : KIND_DATA);

	// ************************************************
	// transmit sequencer
	// ************************************************
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state    <= ST_READY;
			kind     <= KIND_DATA;
			shifter  <= `SHIFT_RESET;
			bitsLeft <= `BITS_RESET;
			lineOut  <= `LINE_RESET;
		end
		else if (clkEn)
		begin
			case (state)
				ST_READY:
				begin
					if (launch)
					begin
						state    <= ST_SEND;
						kind     <= next_kind;
						shifter  <= next_pattern;
						bitsLeft <= next_bits;
						lineOut  <= next_pattern[0];
					end
					else
						lineOut  <= 1'b1;
				end
				ST_SEND:
				begin
					if (launch)
					begin
						// back to back: next character on the same tick
						kind     <= next_kind;
						shifter  <= next_pattern;
						bitsLeft <= next_bits;
						lineOut  <= next_pattern[0];
					end
					else if (slot)
					begin
						state    <= ST_READY;
						kind     <= KIND_DATA;
						lineOut  <= 1'b1;
					end
					else if (baudTick)
					begin
						shifter  <= {1'b1, shifter[`TX_SHIFT_W-1:1]};
						bitsLeft <= 4'(bitsLeft - 4'h1);
						lineOut  <= shifter[1];
					end
				end
				default:
				begin
					state   <= ST_READY;
					lineOut <= 1'b1;
				end
			endcase
		end
	end

	// ************************************************
	// request latches
	// ************************************************
	// the launch clear wins over a new edge; an edge taken by this very launch is used up
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			idlePending  <= 1'b0;
			breakPending <= 1'b0;
			prevTxOn     <= 1'b0;
			prevBreak    <= 1'b0;
		end
		else if (clkEn)
		begin
			prevTxOn     <= tx_on;
			prevBreak    <= break_request;
			idlePending  <= idleWant & ~startIdle;
			breakPending <= (breakRise & ~startBreak) | (breakPending & ~startBreak);
		end
	end

	assign txLine       = lineOut;
	assign txBusy       = (state == ST_SEND);
	assign sendingBreak = (state == ST_SEND) && (kind == KIND_BREAK);

	// ************************************************
	// checks
	// ************************************************
	// count of finished baud periods with the line at space
	logic [4:0] lowRun;
	always_ff @(posedge core_clk)
	begin
		if (rst)
			lowRun <= 5'h00;
		else if (clkEn && baudTick)
			lowRun <= lineOut ? 5'h00 : 5'(lowRun + 5'h01);
	end

	a_break_single: assert property (@(posedge core_clk) disable iff (rst)
		clkEn && breakRise && !startBreak |=> breakPending)
		else $error("break request edge not latched");

	a_break_length: assert property (@(posedge core_clk) disable iff (rst)
		lowRun <= {1'b0, charBits(nine_bit_mode)})
		else $error("space run longer than one break");

	a_break_stop: assert property (@(posedge core_clk) disable iff (rst)
		clkEn && sendingBreak && baudTick && bitsLeft == 4'h1 && !launch |=> lineOut)
		else $error("break not closed by a mark bit");

	a_break_repeat: assert property (@(posedge core_clk) disable iff (rst)
		clkEn && slot && tx_on && !idleWant && break_request |=> sendingBreak && !lineOut)
		else $error("held break request did not repeat");

	a_idle_queue: assert property (@(posedge core_clk) disable iff (rst)
		clkEn && txOnRise && !startIdle |=> idlePending)
		else $error("enable toggle did not queue idle");

	a_idle_first: assert property (@(posedge core_clk) disable iff (rst)
		clkEn && slot && tx_on && idleWant |-> !fifoPop ##1 (txBusy && kind == KIND_IDLE))
		else $error("idle line not sent before other work");

	a_idle_mark: assert property (@(posedge core_clk) disable iff (rst)
		txBusy && kind == KIND_IDLE |-> lineOut && !sendingBreak)
		else $error("idle line shows space");

endmodule : sci_break_idle_transmit

// ===== hw/sci_break_consts.svh
// constants of the break and idle transmitter
// assumes inclusion by bare name from the design files
`ifndef SCI_BREAK_CONSTS_SVH
`define SCI_BREAK_CONSTS_SVH

// data path widths and buffer depth
`define TX_DATA_W        9
`define TX_FIFO_DEPTH    4
`define TX_SHIFT_W       12

// bit times of one character, eight and nine bit words
`define CHAR_BITS_8      4'ha
`define CHAR_BITS_9      4'hb

// line patterns, bit 0 goes out first
`define IDLE_PATTERN     12'h0_fff
`define BREAK_PATTERN_8  12'h0_400
`define BREAK_PATTERN_9  12'h0_800

// reset values
`define SHIFT_RESET      12'h0_fff
`define BITS_RESET       4'h0
`define LINE_RESET       1'h1

`endif

// ===== hw/sci_break_pkg.sv
// types shared by the break and idle transmitter
// assumes the constants header sits beside it
package sci_break_pkg;

	// one-hot transmitter state
	typedef enum logic [1:0]
	{
		ST_READY = 2'b01,
		ST_SEND  = 2'b10
	} tx_state_t;

	// kind of character on the line
	typedef enum logic [1:0]
	{
		KIND_DATA  = 2'b00,
		KIND_BREAK = 2'b01,
		KIND_IDLE  = 2'b10
	} char_kind_t;

endpackage : sci_break_pkg

// ===== hw/tx_fifo.sv
// small flip-flop FIFO with valid and ready on both sides
// assumes one clock, synchronous active-high reset, clock enable
`timescale 1ns/100ps
module tx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             clkEn,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output wire logic             inReady,
	output wire logic [WIDTH-1:0] outData,
	output wire logic             outValid,
	input  wire logic             outReady
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_SLOT  = PW'(DEPTH - 1);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0]    wrPtr;
	logic [PW-1:0]    rdPtr;
	logic [CW-1:0]    count;

	// ************************************************
	// handshake terms
	// ************************************************
	wire push = inValid & inReady;
	wire pop  = outValid & outReady;

	assign inReady  = (count != FULL_COUNT);
	assign outValid = (count != '0);
	assign outData  = store[rdPtr];

	// wrap a pointer at the last slot
	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == LAST_SLOT) ? '0 : PW'(p + 1'b1);
	endfunction : bump

	// pointers and fill level
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end
		else if (clkEn)
		begin
			if (push)
				wrPtr <= bump(wrPtr);
			if (pop)
				rdPtr <= bump(rdPtr);
			if (push != pop)
				count <= push ? CW'(count + 1'b1) : CW'(count - 1'b1);
		end
	end

	// storage write
	always_ff @(posedge core_clk)
	begin
		if (clkEn && push)
			store[wrPtr] <= inData;
	end

endmodule : tx_fifo

// ===== verif/line_receiver.sv
// remote receiver model, samples the serial line once per bit time
// assumes txLine moves only on the edge after an effective baud tick
`timescale 1ns/100ps
module line_receiver
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       tick,
	input  wire logic       nineBit,
	input  wire logic       txLine,
	output logic            frameValid,
	output logic [8:0]      frameData,
	output logic            frameStop,
	output logic [5:0]      frameGap
);
	logic [3:0] pos;
	logic [5:0] gapCnt;
	wire  [3:0] lastPos = nineBit ? 4'ha : 4'h9;

	// low sample opens a frame, marks before it are counted as gap
	always_ff @(posedge core_clk)
	begin
		frameValid <= 1'b0;
		if (rst)
		begin
			pos <= 4'h0;
			gapCnt <= 6'h00;
		end
		else if (tick)
		begin
			if (pos == 4'h0)
			begin
				if (!txLine)
				begin
					pos <= 4'h1;
					frameData <= 9'h000;
				end
				else if (gapCnt != 6'h3f)
					gapCnt <= gapCnt + 6'h01;
			end
			else if (pos == lastPos)
			begin
				frameValid <= 1'b1; // stop sample closes frame
				frameStop <= txLine;
				frameGap <= gapCnt;
				gapCnt <= 6'h00;
				pos <= 4'h0;
			end
			else
			begin
				frameData[pos - 4'h1] <= txLine; // lsb first
				pos <= pos + 4'h1;
			end
		end
	end
endmodule : line_receiver

// ===== verif/tb_top.sv
// self-checking bench of the break and idle transmitter
// assumes the receiver model sits on txLine, ticks every fourth cycle
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        clkEn = 1'b1;
	logic        tx_on = 1'b0;
	logic        break_request = 1'b0;
	logic        nine_bit_mode = 1'b0;
	logic        baudTick = 1'b0;
	logic [8:0]  wrData = 9'h000;
	logic        wrValid = 1'b0;
	logic [1:0]  tickCnt = 2'h0;
	wire         wrReady, txLine, txBusy, sendingBreak, frameValid, frameStop;
	wire  [8:0]  frameData;
	wire  [5:0]  frameGap;
	logic [16:0] notes[$];
	logic [16:0] exp;
	int          checks = 0;
	int          mismatches = 0;
	int          framesSeen = 0;

	sci_break_idle_transmit i_sci_break_idle_transmit (.core_clk(core_clk), .rst(rst),
		.clkEn(clkEn), .tx_on(tx_on), .break_request(break_request),
		.nine_bit_mode(nine_bit_mode), .baudTick(baudTick), .wrData(wrData),
		.wrValid(wrValid), .wrReady(wrReady), .txLine(txLine), .txBusy(txBusy),
		.sendingBreak(sendingBreak));
	line_receiver i_line_receiver (.core_clk(core_clk), .rst(rst), .tick(baudTick & clkEn),
		.nineBit(nine_bit_mode), .txLine(txLine), .frameValid(frameValid),
		.frameData(frameData), .frameStop(frameStop), .frameGap(frameGap));

	// clock, baud tick and random clock enable
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		tickCnt <= tickCnt + 2'h1;
		baudTick <= (tickCnt == 2'h3);
		clkEn <= ($urandom % 8) != 0;
	end

	// each received frame is held against the oldest note
	always @(posedge core_clk)
		if (frameValid)
		begin
			framesSeen++;
			`CHK("frame noted", 1'b1, notes.size() != 0)
			if (notes.size() != 0)
			begin
				exp = notes.pop_front();
				`CHK("data", exp[8:0], frameData)
				`CHK("stop", exp[9], frameStop)
				if (exp[16])
					`CHK("gap", exp[15:10], frameGap)
			end
		end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	// holds the word until taken, caller drops wrValid
	task automatic push(input logic [8:0] w);
		int n;
		n = 0;
		wrData <= w;
		wrValid <= 1'b1;
		do @(posedge core_clk); while (!(wrReady && clkEn) && n++ < 200);
	endtask : push

	task automatic waitFrames(input int k);
		int n;
		n = 0;
		while (framesSeen < k && n < 3000)
		begin
			@(posedge core_clk);
			n++;
		end
		`CHK("frames", 1'b1, framesSeen >= k)
	endtask : waitFrames

	// watchdog
	initial
	begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		report_and_stop();
	end

	initial
	begin
		int base;
		int n;
		logic [8:0] w;
		void'($urandom(32'h1b8e595b));
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		for (int m = 0; m < 2; m++)
		begin
			nine_bit_mode <= m[0];
			tx_on <= 1'b0;
			// fill until refused, then enable drains behind an idle
			base = framesSeen;
			for (int i = 0; i < 4; i++)
			begin
				w = 9'($urandom);
				push(w);
				notes.push_back({i != 0, 6'h00, 1'b1, m[0] ? w : {1'b0, w[7:0]}});
			end
			wrValid <= 1'b0;
			repeat (2) @(posedge core_clk);
			`CHK("full", 1'b0, wrReady)
			`CHK("busy while off", 1'b0, txBusy)
			tx_on <= 1'b1;
			waitFrames(base + 4);
			$display("test data mode %0d done", m);
			// one break, then idle request and break during it
			base = framesSeen;
			break_request <= 1'b1;
			notes.push_back({1'b0, 6'h00, 1'b0, 9'h000});
			notes.push_back({1'b1, 6'(11 + m), 1'b0, 9'h000});
			repeat (4) @(posedge core_clk);
			break_request <= 1'b0;
			n = 0;
			while (sendingBreak !== 1'b1 && n < 500)
			begin
				@(posedge core_clk);
				n++;
			end
			`CHK("break flag", 1'b1, sendingBreak)
			`CHK("busy in break", 1'b1, txBusy)
			tx_on <= 1'b0;
			repeat (4) @(posedge core_clk);
			tx_on <= 1'b1;
			repeat (4) @(posedge core_clk);
			break_request <= 1'b1;
			repeat (4) @(posedge core_clk);
			break_request <= 1'b0;
			w = 9'($urandom);
			push(w);
			wrValid <= 1'b0;
			notes.push_back({1'b1, 6'h01, 1'b1, m[0] ? w : {1'b0, w[7:0]}});
			waitFrames(base + 3);
			$display("test idle break mode %0d done", m);
			// held request repeats, release inside the third break
			base = framesSeen;
			break_request <= 1'b1;
			notes.push_back({1'b0, 6'h00, 1'b0, 9'h000});
			notes.push_back({1'b1, 6'h01, 1'b0, 9'h000});
			notes.push_back({1'b1, 6'h01, 1'b0, 9'h000});
			waitFrames(base + 2);
			repeat (40) @(posedge core_clk);
			break_request <= 1'b0;
			waitFrames(base + 3);
			repeat (120) @(posedge core_clk);
			`CHK("busy after release", 1'b0, txBusy)
			$display("test held break mode %0d done", m);
		end
		`CHK("notes left", 0, notes.size())
		report_and_stop();
	end
endmodule : tb_top
